/* File: logic/cbt_bit_timing.sv */
// Bit timing, sampling and synchronization core with a Wishbone register slave.
//
// Contract
// - Quantum lasts two times prescale plus one.
// - Bit is quanta count, five to 25.
// - Sync segment is exactly one quantum.
// - Propagation segment spans one to eight quanta.
// - Phase one one to eight; sample ends it.
// - Phase two programmable, never below two quanta.
// - Processing time fixed two quanta after sample.
// - Triple sampling votes three half-quantum samples.
// - Hard sync only on idle falling edge.
// - At most one synchronization per bit.
// - Phase error sign from edge position.
// - Small error resyncs like hard sync.
// - Large positive error lengthens phase one.
// - Large negative error shortens phase two.
// - Jump width programmable one to four.
// - Only recessive-to-dominant edges give timing.
// - Edge used only if previous sample differed.
// - Dominant transmitter skips positive error resync.
// - Triple select picks vote or single sample.
// - Phase two source selects field or maximum.
// - Timing settings writable only in configuration.
// - Prescale sits in low six bits.
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module cbt_bit_timing (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Bus line and protocol context
  input wire logic bus_receive_pin,
  input wire logic bus_idle,
  input wire logic tx_dominant,
  // Timing outputs
  output var cbt_pkg::cbt_evt_t evt_o,
  output var cbt_pkg::cbt_seg_t seg_o,
  output logic config_mode_o
);
  localparam int LW = cbt_pkg::LEN_W;

  cbt_pkg::cbt_cfg_t cfg_ff;
  logic config_mode_ff;
  logic ack_ff;
  logic rx_meta_ff;
  logic rx_sync_ff;
  logic rx_prev_ff;
  logic sampled_bit_ff;
  logic synced_ff;
  logic [1:0] hist_ff;
  cbt_pkg::cbt_seg_t seg_ff;
  logic [LW-1:0] tq_cnt_ff;
  logic [LW-1:0] bit_pos_ff;
  logic [LW-1:0] ph1_ext_ff;
  logic [LW-1:0] ph2_cut_ff;

  logic req;
  logic wr_cfg;
  logic half_tq;
  logic tq;
  logic [LW-1:0] jump_len;
  logic [LW-1:0] prop_len;
  logic [LW-1:0] ph1_base;
  logic [LW-1:0] ph1_eff;
  logic [LW-1:0] ph2_prog;
  logic [LW-1:0] ph2_full;
  logic [LW-1:0] ph2_eff;
  logic [LW-1:0] seg_len;
  logic [LW-1:0] neg_mag;
  logic seg_last;
  logic sample_pt;
  logic edge_fall;
  logic edge_ok;
  logic hard_sync;
  logic pos_sync;
  logic neg_sync;
  logic zero_sync;
  logic ext_set;
  logic cut_set;
  logic restart_sync;
  logic restart_div;
  logic vote;
  logic rx_value;
  logic [31:0] rd_data;

  assign req = wb_cyc_i & wb_stb_i;
  assign config_mode_o = config_mode_ff;
  assign seg_o = seg_ff;

  // Wishbone: ack one cycle after the request; writes land on the acked edge.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_ff <= req & ~ack_ff;
      wb_ack_o <= req & ~ack_ff;
      if (req && !ack_ff) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      cbt_pkg::ADR_CFG_ONE: rd_data = {24'h000000, cfg_ff.jump_width, cfg_ff.prescale_value};
      cbt_pkg::ADR_CFG_TWO: rd_data = {24'h000000, cfg_ff.phase2_select_src, cfg_ff.triple_sample_sel,
                                       cfg_ff.phase1_len, cfg_ff.prop_seg_len};
      cbt_pkg::ADR_CFG_THREE: rd_data = {29'h00000000, cfg_ff.phase2_len};
      cbt_pkg::ADR_CTRL: rd_data = {31'h00000000, config_mode_ff};
      cbt_pkg::ADR_STATUS: rd_data = {24'h000000, 2'h0, synced_ff, sampled_bit_ff, seg_ff};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Only the first byte lane holds fields; other lanes are ignored.
  assign wr_cfg = req & ack_ff & wb_we_i & wb_sel_i[0] & (wb_adr_i == cbt_pkg::ADR_CFG_ONE ||
                  wb_adr_i == cbt_pkg::ADR_CFG_TWO || wb_adr_i == cbt_pkg::ADR_CFG_THREE);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cfg_ff <= '0;
    end else if (wr_cfg && config_mode_ff) begin
      case (wb_adr_i)
        cbt_pkg::ADR_CFG_ONE: begin
          cfg_ff.prescale_value <= wb_dat_i[cbt_pkg::FLD_PRESCALE_LSB +: cbt_pkg::PRESCALE_W];
          cfg_ff.jump_width <= wb_dat_i[cbt_pkg::FLD_JUMP_LSB +: cbt_pkg::JUMP_W];
        end
        cbt_pkg::ADR_CFG_TWO: begin
          cfg_ff.prop_seg_len <= wb_dat_i[cbt_pkg::FLD_PROP_LSB +: cbt_pkg::SEG_W];
          cfg_ff.phase1_len <= wb_dat_i[cbt_pkg::FLD_PH1_LSB +: cbt_pkg::SEG_W];
          cfg_ff.triple_sample_sel <= wb_dat_i[cbt_pkg::FLD_TRIPLE_BIT];
          cfg_ff.phase2_select_src <= wb_dat_i[cbt_pkg::FLD_PH2SRC_BIT];
        end
        default: begin
          cfg_ff.phase2_len <= wb_dat_i[cbt_pkg::FLD_PH2_LSB +: cbt_pkg::SEG_W];
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      config_mode_ff <= cbt_pkg::RST_CFGMODE;
    end else if (req && ack_ff && wb_we_i && wb_sel_i[0] && wb_adr_i == cbt_pkg::ADR_CTRL) begin
      config_mode_ff <= wb_dat_i[cbt_pkg::FLD_CFGMODE_BIT];
    end
  end

  // Segment lengths in quanta; each field is stored as length minus one.
  assign jump_len = {3'h0, cfg_ff.jump_width} + cbt_pkg::ONE_TQ;
  assign prop_len = {2'h0, cfg_ff.prop_seg_len} + cbt_pkg::ONE_TQ;
  assign ph1_base = {2'h0, cfg_ff.phase1_len} + cbt_pkg::ONE_TQ;
  assign ph1_eff = ph1_base + ph1_ext_ff;
  // Source clear takes the larger of phase one and processing time, ignoring the field.
  assign ph2_prog = cfg_ff.phase2_select_src ? ({2'h0, cfg_ff.phase2_len} + cbt_pkg::ONE_TQ) :
                    ((ph1_base > cbt_pkg::PROC_TIME_TQ) ? ph1_base : cbt_pkg::PROC_TIME_TQ);
  assign ph2_full = (ph2_prog < cbt_pkg::MIN_PH2_TQ) ? cbt_pkg::MIN_PH2_TQ : ph2_prog;
  assign ph2_eff = ph2_full - ph2_cut_ff;

  always_comb begin
    seg_len = cbt_pkg::ONE_TQ;
    case (seg_ff)
      cbt_pkg::SEG_SYNC: seg_len = cbt_pkg::ONE_TQ;
      cbt_pkg::SEG_PROP: seg_len = prop_len;
      cbt_pkg::SEG_PH1: seg_len = ph1_eff;
      cbt_pkg::SEG_PH2: seg_len = ph2_eff;
      default: seg_len = cbt_pkg::ONE_TQ;
    endcase
  end

  // Bit length is 1 + prop + ph1 + ph2, which spans 5 to 25 quanta.
  assign seg_last = (tq_cnt_ff + cbt_pkg::ONE_TQ) >= seg_len;
  assign sample_pt = tq & seg_last & (seg_ff == cbt_pkg::SEG_PH1) & ~restart_sync;

  // Receive pin crosses in through two flops; only the second one is used.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_meta_ff <= bus_receive_pin;
      rx_sync_ff <= rx_meta_ff;
      rx_prev_ff <= rx_sync_ff;
    end
  end

  assign edge_fall = rx_prev_ff & ~rx_sync_ff;
  assign edge_ok = edge_fall & sampled_bit_ff & ~synced_ff & ~config_mode_ff;
  assign hard_sync = edge_ok & bus_idle;
  assign neg_mag = ph2_eff - tq_cnt_ff;
  assign zero_sync = edge_ok & ~bus_idle & (seg_ff == cbt_pkg::SEG_SYNC);
  // A dominant transmitter sees its own edges late; skipping positive errors avoids chasing itself.
  assign pos_sync = edge_ok & ~bus_idle & ~tx_dominant &
                    (seg_ff == cbt_pkg::SEG_PROP || seg_ff == cbt_pkg::SEG_PH1);
  assign neg_sync = edge_ok & ~bus_idle & (seg_ff == cbt_pkg::SEG_PH2);
  assign ext_set = pos_sync & (bit_pos_ff > jump_len);
  assign cut_set = neg_sync & (neg_mag > jump_len);
  assign restart_sync = hard_sync | (pos_sync & ~ext_set) | (neg_sync & ~cut_set);
  assign restart_div = restart_sync | config_mode_ff;

  cbt_prescaler #(
    .PRESCALE_W(cbt_pkg::PRESCALE_W)
  ) u_prescaler (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .prescale_value(cfg_ff.prescale_value),
    .restart(restart_div),
    .half_tq(half_tq),
    .tq(tq)
  );

  // Segment sequencer; a restart puts the edge inside a fresh sync segment.
  always_ff @(posedge core_clk) begin
    if (!rst_b || config_mode_ff) begin
      seg_ff <= cbt_pkg::SEG_SYNC;
      tq_cnt_ff <= '0;
      bit_pos_ff <= '0;
    end else if (restart_sync) begin
      seg_ff <= cbt_pkg::SEG_SYNC;
      tq_cnt_ff <= '0;
      bit_pos_ff <= '0;
    end else if (tq) begin
      bit_pos_ff <= (seg_ff == cbt_pkg::SEG_PH2 && seg_last) ? '0 : bit_pos_ff + cbt_pkg::ONE_TQ;
      if (seg_last) begin
        tq_cnt_ff <= '0;
        case (seg_ff)
          cbt_pkg::SEG_SYNC: seg_ff <= cbt_pkg::SEG_PROP;
          cbt_pkg::SEG_PROP: seg_ff <= cbt_pkg::SEG_PH1;
          cbt_pkg::SEG_PH1: seg_ff <= cbt_pkg::SEG_PH2;
          cbt_pkg::SEG_PH2: seg_ff <= cbt_pkg::SEG_SYNC;
          default: seg_ff <= cbt_pkg::SEG_SYNC;
        endcase
      end else begin
        tq_cnt_ff <= tq_cnt_ff + cbt_pkg::ONE_TQ;
      end
    end
  end

  // Adjustments live until the next bit starts; the once-per-bit flag clears at the end of phase two, and a restart sets it.
  always_ff @(posedge core_clk) begin
    if (!rst_b || config_mode_ff) begin
      synced_ff <= 1'b0;
      ph1_ext_ff <= '0;
      ph2_cut_ff <= '0;
    end else if (restart_sync) begin
      synced_ff <= 1'b1;
      ph1_ext_ff <= '0;
      ph2_cut_ff <= '0;
    end else if (ext_set || cut_set || zero_sync) begin
      synced_ff <= 1'b1;
      if (ext_set) begin
        ph1_ext_ff <= jump_len;
      end
      if (cut_set) begin
        ph2_cut_ff <= jump_len;
      end
    end else if (tq && seg_last && seg_ff == cbt_pkg::SEG_PH2) begin
      synced_ff <= 1'b0;
      ph1_ext_ff <= '0;
      ph2_cut_ff <= '0;
    end
  end

  // Half-quantum history gives the two earlier samples of the vote.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      hist_ff <= 2'h3;
    end else if (half_tq) begin
      hist_ff <= {hist_ff[0], rx_sync_ff};
    end
  end

  assign vote = (rx_sync_ff & hist_ff[0]) | (rx_sync_ff & hist_ff[1]) | (hist_ff[0] & hist_ff[1]);
  assign rx_value = cfg_ff.triple_sample_sel ? vote : rx_sync_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sampled_bit_ff <= cbt_pkg::RST_SAMPLED;
    end else if (sample_pt) begin
      sampled_bit_ff <= rx_value;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      evt_o <= '0;
    end else begin
      evt_o.tq <= tq;
      evt_o.sample <= sample_pt;
      evt_o.bit_start <= restart_sync | (tq & seg_last & (seg_ff == cbt_pkg::SEG_PH2));
      evt_o.rx_bit <= sample_pt ? rx_value : sampled_bit_ff;
      evt_o.synced <= restart_sync | ext_set | cut_set | zero_sync;
    end
  end

  property p_sync_one_tq;
    @(posedge core_clk) disable iff (!rst_b)
    seg_ff == cbt_pkg::SEG_SYNC && tq && !restart_sync && !config_mode_ff |=> seg_ff == cbt_pkg::SEG_PROP;
  endproperty
  a_sync_one_tq: assert property (p_sync_one_tq) else $error("sync segment not one quantum");

  property p_hard_restart;
    @(posedge core_clk) disable iff (!rst_b)
    hard_sync |=> seg_ff == cbt_pkg::SEG_SYNC && tq_cnt_ff == '0 && synced_ff;
  endproperty
  a_hard_restart: assert property (p_hard_restart) else $error("hard sync did not restart bit");

  property p_one_sync;
    @(posedge core_clk) disable iff (!rst_b)
    synced_ff |-> !restart_sync && !ext_set && !cut_set;
  endproperty
  a_one_sync: assert property (p_one_sync) else $error("second sync in one bit");

  property p_falling_only;
    @(posedge core_clk) disable iff (!rst_b)
    restart_sync || ext_set || cut_set |-> $past(rx_sync_ff) && !rx_sync_ff;
  endproperty
  a_falling_only: assert property (p_falling_only) else $error("sync on non-falling edge");

  property p_prev_differs;
    @(posedge core_clk) disable iff (!rst_b)
    restart_sync || ext_set || cut_set |-> sampled_bit_ff && !rx_sync_ff;
  endproperty
  a_prev_differs: assert property (p_prev_differs) else $error("sync edge matches last sample");

  property p_tx_dom;
    @(posedge core_clk) disable iff (!rst_b)
    tx_dominant && !bus_idle && (seg_ff == cbt_pkg::SEG_PROP || seg_ff == cbt_pkg::SEG_PH1) |-> !restart_sync && !ext_set;
  endproperty
  a_tx_dom: assert property (p_tx_dom) else $error("positive resync while transmitting dominant");

  property p_extend;
    @(posedge core_clk) disable iff (!rst_b)
    ext_set |=> ph1_ext_ff == $past(jump_len) && ph1_eff == ph1_base + $past(jump_len);
  endproperty
  a_extend: assert property (p_extend) else $error("phase one not lengthened by jump width");

  property p_shorten;
    @(posedge core_clk) disable iff (!rst_b)
    cut_set |=> ph2_eff == ph2_full - $past(jump_len);
  endproperty
  a_shorten: assert property (p_shorten) else $error("phase two not shortened by jump width");

  property p_ph2_min;
    @(posedge core_clk) disable iff (!rst_b)
    ph2_full >= cbt_pkg::MIN_PH2_TQ && ph2_full >= (cfg_ff.phase2_select_src ? ph2_full : ph1_base);
  endproperty
  a_ph2_min: assert property (p_ph2_min) else $error("phase two below minimum");

  property p_small_err;
    @(posedge core_clk) disable iff (!rst_b)
    pos_sync && bit_pos_ff <= jump_len |=> seg_ff == cbt_pkg::SEG_SYNC && ph1_ext_ff == '0;
  endproperty
  a_small_err: assert property (p_small_err) else $error("small error did not realign");

  property p_cfg_lock;
    @(posedge core_clk) disable iff (!rst_b)
    wr_cfg && !config_mode_ff |=> $stable(cfg_ff);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("settings changed outside configuration");

  property p_vote;
    @(posedge core_clk) disable iff (!rst_b)
    sample_pt && cfg_ff.triple_sample_sel && hist_ff[0] == hist_ff[1] |=> sampled_bit_ff == $past(hist_ff[0]);
  endproperty
  a_vote: assert property (p_vote) else $error("majority vote wrong");
endmodule // cbt_bit_timing
`default_nettype wire

/* File: logic/cbt_pkg.sv */
// Shared constants and types for the bit timing and synchronization block.
package cbt_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADR_CFG_ONE = 8'h00;
  localparam logic [7:0] ADR_CFG_TWO = 8'h04;
  localparam logic [7:0] ADR_CFG_THREE = 8'h08;
  localparam logic [7:0] ADR_CTRL = 8'h0c;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  // Field widths.
  localparam int PRESCALE_W = 6;
  localparam int JUMP_W = 2;
  localparam int SEG_W = 3;
  localparam int LEN_W = 5;
  // Field positions.
  localparam int FLD_PRESCALE_LSB = 0;
  localparam int FLD_JUMP_LSB = 6;
  localparam int FLD_PROP_LSB = 0;
  localparam int FLD_PH1_LSB = 3;
  localparam int FLD_TRIPLE_BIT = 6;
  localparam int FLD_PH2SRC_BIT = 7;
  localparam int FLD_PH2_LSB = 0;
  localparam int FLD_CFGMODE_BIT = 0;
  // Reset values.
  localparam logic RST_CFGMODE = 1'b1;
  localparam logic RST_SAMPLED = 1'b1;
  // Timing counts in quanta.
  localparam logic [LEN_W-1:0] ONE_TQ = 5'h01;
  localparam logic [LEN_W-1:0] PROC_TIME_TQ = 5'h02;
  localparam logic [LEN_W-1:0] MIN_PH2_TQ = 5'h02;

  typedef struct packed {
    logic [PRESCALE_W-1:0] prescale_value;
    logic [JUMP_W-1:0] jump_width;
    logic [SEG_W-1:0] prop_seg_len;
    logic [SEG_W-1:0] phase1_len;
    logic [SEG_W-1:0] phase2_len;
    logic triple_sample_sel;
    logic phase2_select_src;
  } cbt_cfg_t;

  typedef enum logic [3:0] {
    SEG_SYNC = 4'h1,
    SEG_PROP = 4'h2,
    SEG_PH1 = 4'h4,
    SEG_PH2 = 4'h8
  } cbt_seg_t;

  typedef struct packed {
    logic tq;
    logic sample;
    logic bit_start;
    logic rx_bit;
    logic synced;
  } cbt_evt_t;
endpackage

/* File: logic/cbt_prescaler.sv */
// Time quantum prescaler with half-quantum strobe.
`timescale 1ns/1ps
`default_nettype none
module cbt_prescaler #(
  parameter int PRESCALE_W = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Control
  input wire logic [PRESCALE_W-1:0] prescale_value,
  input wire logic restart,
  // Quantum strobes
  output logic half_tq,
  output logic tq
);
  logic [PRESCALE_W-1:0] div_cnt_ff;
  logic phase_ff;
  logic wrap;
  logic [PRESCALE_W+1:0] gap_ff;
  logic seen_ff;

  // A greater-or-equal compare keeps the divider from running away if the value shrinks mid-count.
  assign wrap = (div_cnt_ff >= prescale_value);

  always_ff @(posedge core_clk) begin
    if (!rst_b || restart) begin
      div_cnt_ff <= '0;
      phase_ff <= 1'b0;
    end else if (wrap) begin
      div_cnt_ff <= '0;
      phase_ff <= ~phase_ff;
    end else begin
      div_cnt_ff <= div_cnt_ff + {{(PRESCALE_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      half_tq <= 1'b0;
      tq <= 1'b0;
    end else begin
      half_tq <= wrap & ~restart;
      tq <= wrap & phase_ff & ~restart;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || restart) begin
      gap_ff <= '0;
      seen_ff <= 1'b0;
    end else if (tq) begin
      gap_ff <= '0;
      seen_ff <= 1'b1;
    end else begin
      gap_ff <= gap_ff + {{(PRESCALE_W+1){1'b0}}, 1'b1};
    end
  end

  property p_tq_period;
    @(posedge core_clk) disable iff (!rst_b)
    tq && seen_ff && !restart |-> gap_ff == {1'b0, prescale_value, 1'b1};
  endproperty
  a_tq_period: assert property (p_tq_period) else $error("quantum period wrong");
endmodule // cbt_prescaler
`default_nettype wire

/* File: tb/cbt_node_model.sv */
// Model of a remote node that drives the shared receive line.
`timescale 1ns/1ps
`default_nettype none
module cbt_node_model (
  // Clock
  input wire logic core_clk,
  // Shared line, recessive high while released
  output logic rx_line
);
  initial rx_line = 1'b1;

  // Drives dominant after a delay in clocks; a width of zero leaves the line dominant.
  task automatic send(input int dly, input int width);
    repeat (dly) @(posedge core_clk);
    rx_line <= 1'b0;
    if (width > 0) begin
      repeat (width) @(posedge core_clk);
      rx_line <= 1'b1;
    end
  endtask

  // The line floats back to recessive through the bus termination.
  task automatic release_line();
    rx_line <= 1'b1;
  endtask
endmodule // cbt_node_model
`default_nettype wire

/* File: tb/test_can_bit_timing_sync.sv */
// Self-checking bench for the bit timing and synchronization block.
`timescale 1ns/1ps
`default_nettype none
module test_can_bit_timing_sync;
  typedef struct {
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] c3;
    int bit_q;
    int samp_q;
  } cbt_row_t;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic bus_idle = 1'b0;
  logic tx_dominant = 1'b0;
  logic rx_line;
  cbt_pkg::cbt_evt_t evt_o;
  cbt_pkg::cbt_seg_t seg_o;
  logic config_mode_o;
  logic [31:0] rd;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  int t;
  int tot;
  int syncs = 0;
  int s0;
  // Register bytes one to three, then bit length and sample point in quanta.
  cbt_row_t rows [6] = '{
    '{8'h00, 8'h80, 8'h00, 5, 3},
    '{8'h02, 8'hbf, 8'h07, 25, 17},
    '{8'h01, 8'h21, 8'h06, 13, 8},
    '{8'h3f, 8'h80, 8'h01, 5, 3},
    '{8'h00, 8'h00, 8'h07, 5, 3},
    '{8'h04, 8'ha1, 8'h01, 10, 8}
  };

  cbt_bit_timing dut (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .bus_receive_pin(rx_line),
    .bus_idle(bus_idle),
    .tx_dominant(tx_dominant),
    .evt_o(evt_o),
    .seg_o(seg_o),
    .config_mode_o(config_mode_o)
  );

  cbt_node_model node (
    .core_clk(core_clk),
    .rx_line(rx_line)
  );

  always #5 core_clk = ~core_clk;

  // The slowest row needs a few thousand clocks, so this ceiling only trips on a hang.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (evt_o.synced === 1'b1) begin
      syncs <= syncs + 1;
    end
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got, input int tol);
    logic bad;
    samples_checked++;
    bad = (tol == 0) ? (got !== exp) : (got > exp + tol || got + tol < exp);
    if (bad !== 1'b0) begin
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      errors++;
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    chk("wb_ack_cycles", 32'h2, k, 0);
  endtask

  task automatic cfg(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
    wb(1'b1, cbt_pkg::ADR_CTRL, 32'h1);
    wb(1'b1, cbt_pkg::ADR_CFG_ONE, {24'h0, c1});
    wb(1'b1, cbt_pkg::ADR_CFG_TWO, {24'h0, c2});
    wb(1'b1, cbt_pkg::ADR_CFG_THREE, {24'h0, c3});
    wb(1'b1, cbt_pkg::ADR_CTRL, 32'h0);
  endtask

  // Counts clocks until the chosen event pulse; the bound keeps a dead engine from hanging here.
  task automatic wait_ev(input int f);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (evt_o[f] !== 1'b1 && n < 3000);
  endtask

  // Places falling edges at fixed clocks after a bit start and times the following k sample points.
  task automatic edge_case(input logic idle, input logic txd, input int off, input int wid,
                           input int off2, input int k, input int exp, input int eb, input int es);
    node.release_line();
    bus_idle <= idle;
    tx_dominant <= txd;
    wait_ev(2);
    wait_ev(2);
    s0 = syncs;
    fork
      node.send(off, wid);
      if (off2 > 0) node.send(off2, 0);
    join_none
    tot = 0;
    repeat (k) begin
      wait_ev(3);
      tot += n;
    end
    chk("sample_after_edge", exp, tot, 6);
    chk("sync_count", es, syncs - s0, 0);
    if (eb >= 0) begin
      repeat (2) @(posedge core_clk);
      chk("rx_bit", eb, {31'h0, evt_o.rx_bit}, 0);
    end
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk("seg_o", 32'h1, {28'h0, seg_o}, 0);
    wb(1'b0, cbt_pkg::ADR_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd, 0);
    wb(1'b0, cbt_pkg::ADR_STATUS, 32'h0);
    chk("status", 32'h11, rd, 0);
    wb(1'b0, cbt_pkg::ADR_CFG_ONE, 32'h0);
    chk("cfg_one_rst", 32'h0, rd, 0);
    wb(1'b1, cbt_pkg::ADR_CFG_ONE, 32'hff);
    wb(1'b0, cbt_pkg::ADR_CFG_ONE, 32'h0);
    chk("cfg_one", 32'hff, rd, 0);
    wb(1'b1, cbt_pkg::ADR_CFG_THREE, 32'hff);
    wb(1'b0, cbt_pkg::ADR_CFG_THREE, 32'h0);
    chk("cfg_three", 32'h07, rd, 0);
    wb(1'b1, 8'h14, 32'hff);
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rd, 0);
    foreach (rows[i]) begin
      cfg(rows[i].c1, rows[i].c2, rows[i].c3);
      t = 2 * (rows[i].c1[5:0] + 1);
      wait_ev(2);
      wait_ev(2);
      chk("bit_clocks", t * rows[i].bit_q, n, 0);
      wait_ev(3);
      chk("sample_clocks", t * rows[i].samp_q, n, 0);
      wait_ev(4);
      wait_ev(4);
      chk("tq_clocks", t, n, 0);
    end
    chk("config_mode", 32'h0, {31'h0, config_mode_o}, 0);
    wb(1'b1, cbt_pkg::ADR_CFG_ONE, 32'h3f);
    wb(1'b0, cbt_pkg::ADR_CFG_ONE, 32'h0);
    chk("cfg_locked", {24'h0, rows[5].c1}, rd, 0);
    // Quantum of 10 clocks, jump 2, bit of 11 quanta with the sample 70 clocks in.
    cfg(8'h44, 8'h99, 8'h03);
    edge_case(1'b1, 1'b0, 35, 0, 0, 1, 108, -1, 1);
    edge_case(1'b1, 1'b0, 35, 5, 50, 1, 108, -1, 1);
    edge_case(1'b0, 1'b0, 15, 0, 0, 1, 88, -1, 1);
    edge_case(1'b0, 1'b0, 55, 0, 0, 1, 90, -1, 1);
    edge_case(1'b0, 1'b1, 55, 0, 0, 1, 70, -1, 0);
    edge_case(1'b0, 1'b0, 74, 0, 0, 2, 160, -1, 1);
    // Edge two quanta into phase two: the negative error fits the jump, so the bit restarts.
    edge_case(1'b0, 1'b0, 88, 0, 0, 2, 163, -1, 1);
    cfg(8'h44, 8'hd9, 8'h03);
    edge_case(1'b0, 1'b1, 64, 6, 0, 1, 70, 1, 0);
    cfg(8'h44, 8'h99, 8'h03);
    edge_case(1'b0, 1'b1, 64, 6, 0, 1, 70, 0, 0);
    end_of_test();
  end
endmodule // test_can_bit_timing_sync
`default_nettype wire
